// >>> rtl/erpc_consts.vh
// Functional notes
// - Per-input sense select, 0 low level, 1 falling edge.
// - Level sense sets flag while input low.
// - Edge sense sets flag on high-to-low change.
// - Flag clears by reading 1, then writing 0.
// - Level sense clears on handling with input high.
// - Edge sense clears once handling is carried out.
// - Flags bits 4..0 accept only 0, reset 0.
// - Enable bits 4..0 gate requests, reset 0.
// - Priority bit 0 low level, 1 high level.
// - Register A maps requests, watchdog, timers 0..2.
// - Register B maps timers 3..4, serial, converter.
`ifndef ERPC_CONSTS_VH
`define ERPC_CONSTS_VH

// Register indices; the byte address is four times the index.
`define ERPC_IDX_SENSE      8'hf4
`define ERPC_IDX_ENABLE     8'hf5
`define ERPC_IDX_PENDING    8'hf6
`define ERPC_IDX_PRIO_A     8'hf8
`define ERPC_IDX_PRIO_B     8'hf9
`define ERPC_IDX_EVT_STAT   8'hfc
`define ERPC_IDX_EVT_CLR    8'hfd
`define ERPC_IDX_EVT_EN     8'hfe

`define ERPC_RST_BYTE       8'h00
`define ERPC_ZERO_WORD      32'h0000_0000
`define ERPC_NIRQ           5
`define ERPC_NSRC           13
`define ERPC_SYNC_IDLE      1'b1

// Source numbers: requests 0..4, watchdog, timers 0..4, serial, converter.
`define ERPC_SRC_WDT        4'h5
`define ERPC_SRC_TMR0       4'h6
`define ERPC_SRC_TMR1       4'h7
`define ERPC_SRC_TMR2       4'h8
`define ERPC_SRC_TMR3       4'h9
`define ERPC_SRC_TMR4       4'ha
`define ERPC_SRC_SER        4'hb
`define ERPC_SRC_CONV       4'hc
`define ERPC_SRC_NONE       4'hf

// Priority bit positions.
`define ERPC_PA_REQ0        7
`define ERPC_PA_REQ1        6
`define ERPC_PA_REQ23       5
`define ERPC_PA_REQ4        4
`define ERPC_PA_WDT         3
`define ERPC_PA_TMR0        2
`define ERPC_PA_TMR1        1
`define ERPC_PA_TMR2        0
`define ERPC_PB_TMR3        7
`define ERPC_PB_TMR4        6
`define ERPC_PB_SER         3
`define ERPC_PB_CONV        1

`endif

// >>> rtl/erpc_sync.v
`include "erpc_consts.vh"
`default_nettype none

// Three-stage synchroniser with a two-stage agreement filter per bit.
module erpc_sync #(
	parameter W = 5
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         ce_i,
	// Data
	input  wire [W-1:0] async_i,
	output wire [W-1:0] stable_o
);

	genvar g;

	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg meta;
			reg s2;
			reg s3;
			reg stable;

			// Only the second stage reads the first one.
			always @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					meta   <= `ERPC_SYNC_IDLE;
					s2     <= `ERPC_SYNC_IDLE;
					s3     <= `ERPC_SYNC_IDLE;
					stable <= `ERPC_SYNC_IDLE;
				end else if (ce_i) begin
					meta <= async_i[g];
					s2   <= meta;
					s3   <= s2;
					if (s2 == s3) begin
						stable <= s3;
					end
				end
			end

			assign stable_o[g] = stable;
		end
	endgenerate

endmodule

`default_nettype wire

// >>> rtl/erpc_top.v
`include "erpc_consts.vh"
`default_nettype none

module erpc_top #(
	parameter ADDR_W = 12
) (
	// Clock, reset and clock enable
	input  wire              clk_i,
	input  wire              rst_i,
	input  wire              ce_i,

	// AHB-Lite slave
	input  wire              hsel_i,
	input  wire [ADDR_W-1:0] haddr_i,
	input  wire [1:0]        htrans_i,
	input  wire              hwrite_i,
	input  wire [2:0]        hsize_i,
	input  wire              hready_i,
	input  wire [31:0]       hwdata_i,
	output reg  [31:0]       hrdata_o,
	output wire              hreadyout_o,
	output wire              hresp_o,

	// External request pins
	input  wire [4:0]        ext_req_pin_i,

	// On-chip sources: watchdog, timers 0..4, serial, converter
	input  wire [7:0]        int_src_i,

	// Request presented to the CPU
	output reg               cpu_req_o,
	output reg  [3:0]        cpu_req_src_o,
	output reg               cpu_req_level_o,

	// Exception handling acknowledge from the CPU
	input  wire              cpu_ack_i,
	input  wire [3:0]        cpu_ack_src_i,

	// Event interrupt
	output wire              irq_o
);

	reg  [7:0]  request_sense_select;
	reg  [7:0]  request_enable;
	reg  [4:0]  pending_flag_bit;
	reg  [7:0]  priority_level_a;
	reg  [7:0]  priority_level_b;
	reg  [4:0]  evt_status;
	reg  [4:0]  evt_enable;
	reg  [4:0]  clear_armed;

	reg         wr_pend;
	reg  [7:0]  wr_idx;
	reg         rd_pend;
	reg  [7:0]  rd_idx;

	reg  [4:0]  pin_prev;
	wire [4:0]  pin_level;

	reg  [4:0]  next_pending;
	reg  [4:0]  flag_set;
	reg  [4:0]  flag_clr;
	reg  [4:0]  next_armed;
	reg  [4:0]  next_evt_status;

	reg  [12:0] src_active;
	reg         next_req;
	reg  [3:0]  next_src;
	reg         next_level;
	reg  [3:0]  hi_src;
	reg  [3:0]  lo_src;
	reg         hi_hit;
	reg         lo_hit;
	// Each combinational process owns its own loop index.
	integer     k;
	integer     j;

	wire        addr_phase;
	wire [7:0]  addr_idx;
	wire        wr_pending_reg;
	wire        wr_evt_clr;

	// Priority level of a source, looked up from both priority registers.
	function src_prio;
		input [3:0] src;
		input [7:0] pa;
		input [7:0] pb;
		begin
			case (src)
				4'h0: src_prio = pa[`ERPC_PA_REQ0];
				4'h1: src_prio = pa[`ERPC_PA_REQ1];
				4'h2: src_prio = pa[`ERPC_PA_REQ23];
				4'h3: src_prio = pa[`ERPC_PA_REQ23];
				4'h4: src_prio = pa[`ERPC_PA_REQ4];
				`ERPC_SRC_WDT: src_prio = pa[`ERPC_PA_WDT];
				`ERPC_SRC_TMR0: src_prio = pa[`ERPC_PA_TMR0];
				`ERPC_SRC_TMR1: src_prio = pa[`ERPC_PA_TMR1];
				`ERPC_SRC_TMR2: src_prio = pa[`ERPC_PA_TMR2];
				`ERPC_SRC_TMR3: src_prio = pb[`ERPC_PB_TMR3];
				`ERPC_SRC_TMR4: src_prio = pb[`ERPC_PB_TMR4];
				`ERPC_SRC_SER: src_prio = pb[`ERPC_PB_SER];
				`ERPC_SRC_CONV: src_prio = pb[`ERPC_PB_CONV];
				default: src_prio = 1'b0;
			endcase
		end
	endfunction

	// Read value of one register index.
	function [7:0] reg_read;
		input [7:0] idx;
		input [7:0] sense;
		input [7:0] enable;
		input [4:0] pending;
		input [7:0] pa;
		input [7:0] pb;
		input [4:0] estat;
		input [4:0] een;
		begin
			case (idx)
				`ERPC_IDX_SENSE:    reg_read = sense;
				`ERPC_IDX_ENABLE:   reg_read = enable;
				`ERPC_IDX_PENDING:  reg_read = {3'h0, pending};
				`ERPC_IDX_PRIO_A:   reg_read = pa;
				`ERPC_IDX_PRIO_B:   reg_read = pb;
				`ERPC_IDX_EVT_STAT: reg_read = {3'h0, estat};
				`ERPC_IDX_EVT_EN:   reg_read = {3'h0, een};
				default:            reg_read = `ERPC_RST_BYTE;
			endcase
		end
	endfunction

	// Pins cross into the clock domain before any detection.
	erpc_sync #(
		.W(`ERPC_NIRQ)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.async_i (ext_req_pin_i),
		.stable_o(pin_level)
	);

	// Bus front end. Writes finish with no wait; reads take one wait
	// state so that a write in the preceding data phase is already
	// visible and the read side effect on the flags sees settled state.
	assign addr_phase  = hsel_i & htrans_i[1] & hready_i;
	assign addr_idx    = haddr_i[9:2];
	assign hreadyout_o = ~rd_pend;
	assign hresp_o     = 1'b0;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_pend <= 1'b0;
			wr_idx  <= `ERPC_RST_BYTE;
			rd_pend <= 1'b0;
			rd_idx  <= `ERPC_RST_BYTE;
		end else if (ce_i) begin
			wr_pend <= addr_phase & hwrite_i;
			rd_pend <= addr_phase & ~hwrite_i;
			if (addr_phase) begin
				wr_idx <= addr_idx;
				rd_idx <= addr_idx;
			end
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hrdata_o <= `ERPC_ZERO_WORD;
		end else if (ce_i && rd_pend) begin
			hrdata_o <= {24'h000000, reg_read(rd_idx, request_sense_select,
				request_enable, pending_flag_bit, priority_level_a,
				priority_level_b, evt_status, evt_enable)};
		end
	end

	assign wr_pending_reg = wr_pend & (wr_idx == `ERPC_IDX_PENDING);
	assign wr_evt_clr     = wr_pend & (wr_idx == `ERPC_IDX_EVT_CLR);

	// Plain read/write registers.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			request_sense_select <= `ERPC_RST_BYTE;
			request_enable       <= `ERPC_RST_BYTE;
			priority_level_a     <= `ERPC_RST_BYTE;
			priority_level_b     <= `ERPC_RST_BYTE;
			evt_enable           <= 5'h00;
		end else if (ce_i && wr_pend) begin
			case (wr_idx)
				`ERPC_IDX_SENSE: begin
					request_sense_select <= hwdata_i[7:0];
				end
				`ERPC_IDX_ENABLE: begin
					request_enable <= hwdata_i[7:0];
				end
				`ERPC_IDX_PRIO_A: begin
					priority_level_a <= hwdata_i[7:0];
				end
				`ERPC_IDX_PRIO_B: begin
					priority_level_b <= hwdata_i[7:0];
				end
				`ERPC_IDX_EVT_EN: begin
					evt_enable <= hwdata_i[4:0];
				end
				default: begin
					evt_enable <= evt_enable;
				end
			endcase
		end
	end

	// Pending flags: set terms win over every clear term.
	always @* begin
		flag_set = 5'h00;
		flag_clr = 5'h00;
		for (k = 0; k < `ERPC_NIRQ; k = k + 1) begin
			if (request_sense_select[k]) begin
				// Falling edge of the filtered pin.
				flag_set[k] = pin_prev[k] & ~pin_level[k];
			end else begin
				flag_set[k] = ~pin_level[k];
			end
			if (cpu_ack_i && cpu_ack_src_i == {1'b0, k[2:0]}) begin
				if (request_sense_select[k]) begin
					flag_clr[k] = 1'b1;
				end else begin
					flag_clr[k] = pin_level[k];
				end
			end
			// A written 1 does nothing; a 0 needs an earlier read of 1.
			if (wr_pending_reg && !hwdata_i[k] && clear_armed[k]) begin
				flag_clr[k] = 1'b1;
			end
		end
		next_pending = flag_set | (pending_flag_bit & ~flag_clr);
	end

	// A read arms exactly the bits it saw as 1; a write to the pending register disarms.
	always @* begin
		next_armed = clear_armed & next_pending;
		if (ce_i && rd_pend && rd_idx == `ERPC_IDX_PENDING) begin
			next_armed = pending_flag_bit;
		end else if (wr_pending_reg) begin
			next_armed = 5'h00;
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pending_flag_bit <= 5'h00;
			clear_armed      <= 5'h00;
			pin_prev         <= {`ERPC_NIRQ{`ERPC_SYNC_IDLE}};
		end else if (ce_i) begin
			pending_flag_bit <= next_pending;
			clear_armed      <= next_armed;
			pin_prev         <= pin_level;
		end
	end

	// Event status: a new flag setting is sticky until cleared by a 1.
	always @* begin
		next_evt_status = evt_status;
		if (wr_evt_clr) begin
			next_evt_status = evt_status & ~hwdata_i[4:0];
		end
		next_evt_status = next_evt_status |
			(next_pending & ~pending_flag_bit);
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			evt_status <= 5'h00;
		end else if (ce_i) begin
			evt_status <= next_evt_status;
		end
	end

	assign irq_o = |(evt_status & evt_enable);

	// Request arbitration across all thirteen sources.
	always @* begin
		src_active = {int_src_i,
			pending_flag_bit & request_enable[4:0]};
		hi_hit = 1'b0;
		lo_hit = 1'b0;
		hi_src = `ERPC_SRC_NONE;
		lo_src = `ERPC_SRC_NONE;
		// Scan from the top so that the lowest number is kept last.
		for (j = `ERPC_NSRC; j > 0; j = j - 1) begin
			if (src_active[j-1]) begin
				if (src_prio(j[3:0] - 4'h1, priority_level_a,
					priority_level_b)) begin
					hi_hit = 1'b1;
					hi_src = j[3:0] - 4'h1;
				end else begin
					lo_hit = 1'b1;
					lo_src = j[3:0] - 4'h1;
				end
			end
		end
		next_req = hi_hit | lo_hit;
		if (hi_hit) begin
			next_src   = hi_src;
			next_level = 1'b1;
		end else begin
			next_src   = lo_src;
			next_level = 1'b0;
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cpu_req_o       <= 1'b0;
			cpu_req_src_o   <= `ERPC_SRC_NONE;
			cpu_req_level_o <= 1'b0;
		end else if (ce_i) begin
			cpu_req_o       <= next_req;
			cpu_req_src_o   <= next_src;
			cpu_req_level_o <= next_level;
		end
	end

endmodule

`default_nettype wire

// >>> tb/erpc_chk.sv
`default_nettype none
module erpc_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        hsel_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic        hready_i,
	input wire logic        hreadyout_o,
	input wire logic [31:0] hrdata_o,
	input wire logic [4:0]  ext_req_pin_i,
	input wire logic [7:0]  int_src_i,
	input wire logic        cpu_req_o,
	input wire logic [3:0]  cpu_req_src_o,
	input wire logic        cpu_ack_i,
	input wire logic [3:0]  cpu_ack_src_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take = hsel_i && htrans_i[1] && hready_i;

	a_src_range: assert property (cpu_req_o |-> cpu_req_src_o <= 4'hc)
		else $error("request source out of range");
	a_idle_src: assert property (!cpu_req_o |-> cpu_req_src_o == 4'hf)
		else $error("idle source is not none");
	a_int_present: assert property (
		(int_src_i != 8'h00) [*3] |-> cpu_req_o)
		else $error("on-chip request not presented");
	a_read_wait: assert property (
		take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	a_write_now: assert property (take && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	a_rdata_hold: assert property (
		$changed(hrdata_o) |-> !$past(hreadyout_o))
		else $error("read data moved outside a read");
	a_ack_clears: assert property (
		(ext_req_pin_i == 5'h1f) [*6] ##0 (cpu_ack_i
		&& cpu_req_src_o < 4'h5 && cpu_ack_src_i == cpu_req_src_o)
		|=> ##1 cpu_req_src_o != $past(cpu_req_src_o, 2))
		else $error("handled request still presented");
	// A pin that falls now must not reach the core within two edges.
	a_sync_lag: assert property (
		(ext_req_pin_i == 5'h1f) [*6] ##0 (!cpu_req_o && !hsel_i
		&& !$past(hsel_i) && int_src_i == 8'h00)
		##1 (int_src_i == 8'h00 && !hsel_i) [*2] |-> !cpu_req_o)
		else $error("pin request bypassed the synchroniser");
endmodule

bind erpc_top erpc_chk erpc_chk_inst (.clk_i, .rst_i, .hsel_i, .htrans_i,
	.hwrite_i, .hready_i, .hreadyout_o, .hrdata_o, .ext_req_pin_i,
	.int_src_i, .cpu_req_o, .cpu_req_src_o, .cpu_ack_i, .cpu_ack_src_i);
`default_nettype wire

// >>> tb/erpc_cpu_model.sv
`default_nettype none
// Answers a standing request after delay_i plus two spare cycles, as the core would.
module erpc_cpu_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       en_i,
	input  wire logic [7:0] delay_i,
	input  wire logic       req_i,
	input  wire logic [3:0] src_i,
	output logic            ack_o,
	output logic [3:0]      ack_src_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] cnt;
	// Two spare cycles let the source settle, so no stale one is answered.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			ack_src_o <= 4'h0;
			cnt <= 9'h000;
		end else if (ack_o || !req_i || !en_i) begin
			ack_o <= 1'b0;
			cnt <= 9'h000;
		end else if (cnt < {1'b0, delay_i} + 9'h002) begin
			cnt <= cnt + 9'h001;
		end else begin
			ack_o <= 1'b1;
			ack_src_o <= src_i;
		end
	end
endmodule
`default_nettype wire

// >>> tb/external_request_priority_ctrl_bench.sv
`include "erpc_consts.vh"
`default_nettype none
module external_request_priority_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [4:0]  pins = 5'h1f;
	logic [7:0]  isrc = 8'h00;
	logic        cpu_on = 1'b0;
	logic [7:0]  dly = 8'h00;
	logic [7:0]  rd, v, pa, pb;
	wire  [31:0] hrdata;
	wire         hrdy, hresp, req, lvl, ack, irq;
	wire  [3:0]  src, ack_src;
	int          bad_count = 0;
	int          comparisons = 0;
	logic [7:0]  idx [7] = '{`ERPC_IDX_SENSE, `ERPC_IDX_ENABLE,
		`ERPC_IDX_PENDING, `ERPC_IDX_PRIO_A, `ERPC_IDX_PRIO_B,
		`ERPC_IDX_EVT_STAT, `ERPC_IDX_EVT_EN};

	erpc_top erpc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'b010), .hready_i(hrdy),
		.hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hrdy),
		.hresp_o(hresp), .ext_req_pin_i(pins), .int_src_i(isrc),
		.cpu_req_o(req), .cpu_req_src_o(src), .cpu_req_level_o(lvl),
		.cpu_ack_i(ack), .cpu_ack_src_i(ack_src), .irq_o(irq));
	erpc_cpu_model erpc_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.en_i(cpu_on), .delay_i(dly), .req_i(req), .src_i(src),
		.ack_o(ack), .ack_src_o(ack_src));

	always #5 clk_i = ~clk_i;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {2'b00, i, 2'b00};
		do @(posedge clk_i); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge clk_i); while (hrdy !== 1'b1);
		rd = hrdata[7:0];
	endtask
	task automatic rchk(input logic [7:0] i, input logic [7:0] exp);
		bus(1'b0, i, 8'h00);
		check(rd, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// The pin is held low long enough to pass the agreement filter.
	task automatic pulse(input logic [4:0] m);
		pins <= ~m;
		cyc(6);
		pins <= 5'h1f;
		cyc(8);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [4:0] win(input logic [7:0] s, a, b);
		logic [7:0] lv;
		lv = {b[1], b[3], b[6], b[7], a[0], a[1], a[2], a[3]};
		for (int p = 1; p >= 0; p--)
			for (int k = 0; k < 8; k++)
				if (s[k] && lv[k] == p[0])
					return {p[0], 4'(k + 5)};
		return 5'h0f;
	endfunction

	initial begin
		void'($urandom(32'h6948));
		cyc(2);
		rst_i <= 1'b0;
		cyc(1);
		foreach (idx[i]) rchk(idx[i], 8'h00);
		check({7'h0, hresp}, 8'h00);
		bus(1'b1, 8'h10, 8'hff);
		rchk(8'h10, 8'h00);
		for (int i = 0; i < 5; i++) if (i != 2) begin
			v = 8'($urandom);
			bus(1'b1, idx[i], v);
			rchk(idx[i], v);
			bus(1'b1, idx[i], 8'h00);
		end
		$display("test registers done");
		bus(1'b1, `ERPC_IDX_ENABLE, 8'h04);
		pins <= 5'h1b;
		cyc(8);
		check({3'h0, req, src}, 8'h12);
		rchk(`ERPC_IDX_PENDING, 8'h04);
		rchk(`ERPC_IDX_EVT_STAT, 8'h04);
		foreach (idx[i]) if (i < 4) begin
			bus(1'b1, i[1] ? `ERPC_IDX_EVT_CLR : `ERPC_IDX_EVT_EN,
				i[0] ? 8'h00 : 8'h04);
			cyc(1);
			check({7'h0, irq}, {7'h0, i == 0});
		end
		cpu_on <= 1'b1;
		dly <= 8'($urandom % 8);
		cyc(12);
		rchk(`ERPC_IDX_PENDING, 8'h04);
		pins <= 5'h1f;
		cyc(30);
		rchk(`ERPC_IDX_PENDING, 8'h00);
		cpu_on <= 1'b0;
		$display("test level done");
		bus(1'b1, `ERPC_IDX_SENSE, 8'h02);
		bus(1'b1, `ERPC_IDX_ENABLE, 8'h02);
		pulse(5'h02);
		bus(1'b1, `ERPC_IDX_PENDING, 8'h00);
		rchk(`ERPC_IDX_PENDING, 8'h02);
		bus(1'b1, `ERPC_IDX_PENDING, 8'hff);
		rchk(`ERPC_IDX_PENDING, 8'h02);
		bus(1'b1, `ERPC_IDX_PENDING, 8'h00);
		rchk(`ERPC_IDX_PENDING, 8'h00);
		cpu_on <= 1'b1;
		dly <= 8'($urandom % 16);
		pulse(5'h02);
		cyc(30);
		rchk(`ERPC_IDX_PENDING, 8'h00);
		cpu_on <= 1'b0;
		bus(1'b1, `ERPC_IDX_SENSE, 8'h10);
		bus(1'b1, `ERPC_IDX_ENABLE, 8'h00);
		pulse(5'h10);
		check({3'h0, req, src}, 8'h0f);
		rchk(`ERPC_IDX_PENDING, 8'h10);
		bus(1'b1, `ERPC_IDX_PENDING, 8'h00);
		$display("test edge done");
		bus(1'b1, `ERPC_IDX_ENABLE, 8'h08);
		bus(1'b1, `ERPC_IDX_PRIO_B, 8'h80);
		isrc <= 8'h10;
		pins <= 5'h17;
		cyc(8);
		check({3'h0, lvl, src}, 8'h19);
		bus(1'b1, `ERPC_IDX_PRIO_A, 8'h20);
		cyc(3);
		check({3'h0, lvl, src}, 8'h13);
		pins <= 5'h1f;
		cyc(8);
		rchk(`ERPC_IDX_PENDING, 8'h08);
		bus(1'b1, `ERPC_IDX_PENDING, 8'h00);
		for (int t = 0; t < 24; t++) begin
			pa = 8'($urandom);
			pb = 8'($urandom);
			v = (t == 0) ? 8'h00 : 8'($urandom);
			bus(1'b1, `ERPC_IDX_PRIO_A, pa);
			bus(1'b1, `ERPC_IDX_PRIO_B, pb);
			isrc <= v;
			cyc(4);
			check({3'h0, lvl, src}, {3'h0, win(v, pa, pb)});
		end
		isrc <= 8'h00;
		$display("test priority done");
		end_of_test();
	end

	initial begin
		cyc(20000);
		bad_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
